// ==== core/cpc_ctl.v ====
// Contract
// - polarity clear: output high when input above reference, else low
// - polarity set: output low when input above reference, else high
// - config_b bit 4 selects the 1.2V or 2V comparator reference
// - battery only: comparator off unless monitor enable; info bit 15 shows reference
// - enable clear, compare-disable clear: pins are comparator, output function off
// - enable clear, compare-disable set: both functions off, pins ignored
// - both functions on; output needs battery above limit; info bits read 11
// - both set: pins become enable input and power-good; output needs all three
// - adapter over limit 10us: open switch, flag low, stop switching, battery gate on
// - adapter below release 100us: switch back on, switching restarts
// - system above ceiling plus margin: flag overvoltage, stop switching
// - system below threshold minus hysteresis: resume switching at once
// - adapter and battery currents each compared against own trip level
// - each 20us slot with a trip adds at most one count
// - seven counts within 656ms: open switch, flag low, stop switching
// - after overcurrent shutdown wait long or short debounce, then restart
// - config_b bit 1 disables overcurrent detection and shutdown
// - over-temperature: regulator off until 100us after dropping below lower release threshold
// - no switching in over-temperature; after release wait 100us, then resume
// - output function switching starts after long or short debounce
`timescale 1ns/100ps
`default_nettype none
`include "cpc_map.vh"

module cpc_ctl #(
	parameter OC_WIN_CYC = `CPC_OC_WIN_CYC,  // overcurrent window
	parameter LONG_CYC   = `CPC_LONG_CYC,    // long debounce
	parameter SHORT_CYC  = `CPC_SHORT_CYC    // short debounce
) (
	input  wire        clk,                  // 250 MHz clock
	input  wire        reset,                // sync reset, high
	input  wire        reg_wr,               // register write strobe
	input  wire        reg_rd,               // register read strobe
	input  wire [7:0]  reg_addr,             // register address
	input  wire [15:0] reg_wdata,            // write data
	output reg  [15:0] reg_rdata,            // read data
	input  wire        shared_enable_or_cmp_in_pin, // comparator above ref, or enable
	output reg         shared_pgood_or_cmp_out_pin, // comparator out or power-good
	input  wire        cmp_above_ref_low,    // analog: input above 1.2V ref
	input  wire        cmp_above_ref_high,   // analog: input above 2V ref
	input  wire        battery_only,         // no adapter attached
	input  wire        battery_above_limit,  // battery above 5.8V
	input  wire        output_rail_good,     // output rail within window
	input  wire        adapter_sense_over,   // adapter above 23.4V
	input  wire        adapter_sense_release,// adapter below 23.04V
	input  wire        system_rail_over,     // system above ceiling + 600mV
	input  wire        system_rail_release,  // system 300mV below threshold
	input  wire        adapter_current_trip, // adapter above 12A
	input  wire        battery_current_trip, // discharge above 16A
	input  wire        temp_over,            // junction above 140C
	input  wire        temp_release,         // junction below 120C
	output reg         adapter_switch_gate,  // adapter switch on
	output reg         battery_gate,         // battery gate forced on
	output reg         adapter_present_flag, // adapter ok, high
	output reg         switching_enable,     // converter may switch
	output reg         output_function_on,   // reverse output running
	output reg         regulator_enable,     // internal regulator on
	output reg         system_ov_flag,       // system overvoltage
	output reg         comparator_enable     // comparator powered
);
	localparam [31:0] AOV_QUAL = `CPC_AOV_QUAL_CYC;
	localparam [31:0] AOV_REL  = `CPC_AOV_REL_CYC;
	localparam [31:0] OC_SLOT  = `CPC_OC_SLOT_CYC;
	localparam [31:0] OT_DLY   = `CPC_OT_DELAY_CYC;
	localparam [31:0] OC_WIN   = OC_WIN_CYC;
	localparam [31:0] LONGC    = LONG_CYC;
	localparam [31:0] SHORTC   = SHORT_CYC;
	localparam [2:0]  OC_TRIP  = `CPC_OC_TRIP_COUNT;

	localparam [1:0] OC_RUN  = 2'd0;
	localparam [1:0] OC_WAIT = 2'd1;

	localparam [1:0] OT_OK   = 2'd0;
	localparam [1:0] OT_HOT  = 2'd1;
	localparam [1:0] OT_WAIT = 2'd2;

	reg [15:0] cfg_a_reg;
	reg [15:0] cfg_b_reg;

	// async analog inputs
	wire [13:0] sy;
	cpc_sync #(.W(14)) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({shared_enable_or_cmp_in_pin,
		         cmp_above_ref_low,
		         cmp_above_ref_high,
		         battery_only,
		         battery_above_limit,
		         output_rail_good,
		         adapter_sense_over,
		         adapter_sense_release,
		         system_rail_over,
		         system_rail_release,
		         adapter_current_trip,
		         battery_current_trip,
		         temp_over,
		         temp_release}),
		.q     (sy)
	);
	wire pin_in   = sy[13];
	wire ref_lo   = sy[12];
	wire ref_hi   = sy[11];
	wire bat_only = sy[10];
	wire bat_ok   = sy[9];
	wire rail_ok  = sy[8];
	wire aov      = sy[7];
	wire arel     = sy[6];
	wire sov      = sy[5];
	wire srel     = sy[4];
	wire ia_trip  = sy[3];
	wire ib_trip  = sy[2];
	wire t_over   = sy[1];
	wire t_rel    = sy[0];

	wire out_en_bit  = cfg_a_reg[`CPC_A_OUTPUT_EN];
	wire mon_en_bit  = cfg_a_reg[`CPC_A_MONITOR_EN];
	wire cmp_dis_bit = cfg_b_reg[`CPC_B_CMP_DISABLE];
	wire invert_bit  = cfg_b_reg[`CPC_B_CMP_INVERT];
	wire ref_sel     = cfg_b_reg[`CPC_B_REF_HIGH];
	wire ocp_dis     = cfg_b_reg[`CPC_B_OCP_DISABLE];

	// register writes
	always @(posedge clk) begin
		if (reset) begin
			cfg_a_reg <= `CPC_A_RESET;
			cfg_b_reg <= `CPC_B_RESET;
		end else if (reg_wr) begin
			if (reg_addr == `CPC_ADDR_CFG_A)
				cfg_a_reg <= reg_wdata;
			if (reg_addr == `CPC_ADDR_CFG_B)
				cfg_b_reg <= reg_wdata;
		end
	end

	// comparator path and pin sharing
	wire ref_ready  = !bat_only || mon_en_bit;
	wire cmp_active = !cmp_dis_bit && ref_ready;
	wire cmp_trip   = ref_sel ? ref_hi : ref_lo;
	wire cmp_level  = invert_bit ? !cmp_trip : cmp_trip;
	wire pins_otg   = out_en_bit && cmp_dis_bit;
	wire out_req    = out_en_bit && bat_ok && (!cmp_dis_bit || pin_in);

	// output-function start debounce
	// any drop of the request restarts the whole debounce
	reg [31:0] out_cnt_reg;
	reg        out_run_reg;
	wire [31:0] out_dly = cfg_b_reg[`CPC_B_OUT_SHORT] ? SHORTC : LONGC;
	always @(posedge clk) begin
		if (reset || !out_req) begin
			out_cnt_reg <= 32'h0000_0000;
			out_run_reg <= 1'b0;
		end else if (!out_run_reg) begin
			if (out_cnt_reg >= out_dly - 32'h0000_0001)
				out_run_reg <= 1'b1;
			else
				out_cnt_reg <= out_cnt_reg + 32'h0000_0001;
		end
	end

	// adapter overvoltage: qualify then release
	// one clean sample restarts either count, so glitches never add up
	reg [31:0] aov_cnt_reg;
	reg        aov_reg;
	always @(posedge clk) begin
		if (reset) begin
			aov_cnt_reg <= 32'h0000_0000;
			aov_reg     <= 1'b0;
		end else if (!aov_reg) begin
			if (!aov)
				aov_cnt_reg <= 32'h0000_0000;
			else if (aov_cnt_reg >= AOV_QUAL) begin
				aov_reg     <= 1'b1;
				aov_cnt_reg <= 32'h0000_0000;
			end else
				aov_cnt_reg <= aov_cnt_reg + 32'h0000_0001;
		end else begin
			if (!arel)
				aov_cnt_reg <= 32'h0000_0000;
			else if (aov_cnt_reg >= AOV_REL) begin
				aov_reg     <= 1'b0;
				aov_cnt_reg <= 32'h0000_0000;
			end else
				aov_cnt_reg <= aov_cnt_reg + 32'h0000_0001;
		end
	end

	// system overvoltage, hysteresis only
	reg sov_reg;
	always @(posedge clk) begin
		if (reset)
			sov_reg <= 1'b0;
		else if (sov)
			sov_reg <= 1'b1;
		else if (srel)
			sov_reg <= 1'b0;
	end

	// overcurrent: one count per slot, window, shutdown, debounce
	wire       oc_trip = ia_trip || ib_trip;
	reg [1:0]  oc_state_reg;
	reg [31:0] slot_cnt_reg;
	reg [31:0] win_cnt_reg;
	reg [31:0] oc_wait_reg;
	reg        slot_hit_reg;
	reg [2:0]  oc_cnt_reg;
	wire       slot_end = slot_cnt_reg >= OC_SLOT - 32'h0000_0001;
	wire       win_end  = win_cnt_reg >= OC_WIN - 32'h0000_0001;
	wire [31:0] oc_dly  = cfg_b_reg[`CPC_B_OCP_SHORT] ? SHORTC : LONGC;
	wire [2:0] oc_cnt_inc = oc_cnt_reg + 3'd1;
	always @(posedge clk) begin
		if (reset || ocp_dis) begin
			oc_state_reg <= OC_RUN;
			slot_cnt_reg <= 32'h0000_0000;
			win_cnt_reg  <= 32'h0000_0000;
			oc_wait_reg  <= 32'h0000_0000;
			slot_hit_reg <= 1'b0;
			oc_cnt_reg   <= 3'd0;
		end else begin
			case (oc_state_reg)
				OC_RUN: begin
					slot_cnt_reg <= slot_end ? 32'h0000_0000 : slot_cnt_reg + 32'h0000_0001;
					win_cnt_reg  <= win_end ? 32'h0000_0000 : win_cnt_reg + 32'h0000_0001;
					// a hit on the slot's last edge leaves the mark clear for the next slot
					if (oc_trip && !slot_hit_reg) begin
						slot_hit_reg <= !slot_end;
						if (oc_cnt_inc == OC_TRIP) begin
							oc_state_reg <= OC_WAIT;
							oc_cnt_reg   <= 3'd0;
							oc_wait_reg  <= 32'h0000_0000;
						end else if (win_end)
							oc_cnt_reg <= 3'd0;
						else
							oc_cnt_reg <= oc_cnt_inc;
					end else begin
						if (slot_end)
							slot_hit_reg <= 1'b0;
						if (win_end)
							oc_cnt_reg <= 3'd0;
					end
				end
				OC_WAIT: begin
					slot_cnt_reg <= 32'h0000_0000;
					win_cnt_reg  <= 32'h0000_0000;
					slot_hit_reg <= 1'b0;
					if (oc_wait_reg >= oc_dly - 32'h0000_0001)
						oc_state_reg <= OC_RUN;
					else
						oc_wait_reg <= oc_wait_reg + 32'h0000_0001;
				end
				default: oc_state_reg <= OC_RUN;
			endcase
		end
	end
	wire oc_fault = oc_state_reg == OC_WAIT;

	// over-temperature
	// losing release during the delay returns to the hot state
	reg [1:0]  ot_state_reg;
	reg [31:0] ot_cnt_reg;
	always @(posedge clk) begin
		if (reset) begin
			ot_state_reg <= OT_OK;
			ot_cnt_reg   <= 32'h0000_0000;
		end else begin
			case (ot_state_reg)
				OT_OK:
					if (t_over)
						ot_state_reg <= OT_HOT;
				OT_HOT: begin
					ot_cnt_reg <= 32'h0000_0000;
					if (t_rel)
						ot_state_reg <= OT_WAIT;
				end
				OT_WAIT: begin
					if (!t_rel)
						ot_state_reg <= OT_HOT;
					else if (ot_cnt_reg >= OT_DLY - 32'h0000_0001)
						ot_state_reg <= OT_OK;
					else
						ot_cnt_reg <= ot_cnt_reg + 32'h0000_0001;
				end
				default: ot_state_reg <= OT_OK;
			endcase
		end
	end
	wire ot_fault = ot_state_reg != OT_OK;

	// outputs, all from flops
	// a disabled comparator drives its pin low rather than leaving it stale
	always @(posedge clk) begin
		if (reset) begin
			adapter_switch_gate         <= 1'b0;
			battery_gate                <= 1'b0;
			adapter_present_flag        <= 1'b0;
			switching_enable            <= 1'b0;
			output_function_on          <= 1'b0;
			regulator_enable            <= 1'b0;
			system_ov_flag              <= 1'b0;
			comparator_enable           <= 1'b0;
			shared_pgood_or_cmp_out_pin <= 1'b0;
		end else begin
			adapter_switch_gate  <= !aov_reg && !oc_fault;
			battery_gate         <= aov_reg;
			adapter_present_flag <= !aov_reg && !oc_fault;
			switching_enable     <= !aov_reg && !oc_fault && !sov_reg && !ot_fault;
			output_function_on   <= out_run_reg && !ot_fault;
			regulator_enable     <= !ot_fault;
			system_ov_flag       <= sov_reg;
			comparator_enable    <= cmp_active && !pins_otg;
			if (pins_otg)
				shared_pgood_or_cmp_out_pin <= out_run_reg && rail_ok;
			else if (cmp_active)
				shared_pgood_or_cmp_out_pin <= cmp_level;
			else
				shared_pgood_or_cmp_out_pin <= 1'b0;
		end
	end

	// register reads
	always @(posedge clk) begin
		if (reset)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			case (reg_addr)
				`CPC_ADDR_CFG_A: reg_rdata <= cfg_a_reg;
				`CPC_ADDR_CFG_B: reg_rdata <= cfg_b_reg;
				`CPC_ADDR_INFO: begin
					reg_rdata <= 16'h0000;
					reg_rdata[`CPC_I_REF_ON]  <= ref_ready;
					reg_rdata[`CPC_I_MODE_HI] <= out_run_reg;
					reg_rdata[`CPC_I_MODE_LO] <= out_run_reg;
				end
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule

`default_nettype wire

// ==== shared/cpc_map.vh ====
`ifndef CPC_MAP_VH
`define CPC_MAP_VH

// register addresses
`define CPC_ADDR_INFO        8'h3a
`define CPC_ADDR_CFG_A       8'h3c
`define CPC_ADDR_CFG_B       8'h3d

// config_a fields
`define CPC_A_MONITOR_EN     3
`define CPC_A_OUTPUT_EN      11
`define CPC_A_RESET          16'h0000

// config_b fields
`define CPC_B_OCP_DISABLE    1
`define CPC_B_CMP_INVERT     2
`define CPC_B_CMP_DISABLE    3
`define CPC_B_REF_HIGH       4
`define CPC_B_OCP_SHORT      11
`define CPC_B_OUT_SHORT      13
`define CPC_B_RESET          16'h0000

// info fields
`define CPC_I_REF_ON         15
`define CPC_I_MODE_HI        6
`define CPC_I_MODE_LO        5

// clock and times
`define CPC_CLK_MHZ          250
`define CPC_AOV_QUAL_US      10
`define CPC_AOV_REL_US       100
`define CPC_OC_SLOT_US       20
`define CPC_OC_WIN_MS        656
`define CPC_OC_TRIP_COUNT    3'h7
`define CPC_LONG_MS          1300
`define CPC_SHORT_MS         150
`define CPC_OT_DELAY_US      100
`define CPC_AOV_QUAL_CYC     (`CPC_AOV_QUAL_US * `CPC_CLK_MHZ)
`define CPC_AOV_REL_CYC      (`CPC_AOV_REL_US * `CPC_CLK_MHZ)
`define CPC_OC_SLOT_CYC      (`CPC_OC_SLOT_US * `CPC_CLK_MHZ)
`define CPC_OT_DELAY_CYC     (`CPC_OT_DELAY_US * `CPC_CLK_MHZ)
`define CPC_OC_WIN_CYC       (`CPC_OC_WIN_MS * 1000 * `CPC_CLK_MHZ)
`define CPC_LONG_CYC         (`CPC_LONG_MS * 1000 * `CPC_CLK_MHZ)
`define CPC_SHORT_CYC        (`CPC_SHORT_MS * 1000 * `CPC_CLK_MHZ)

`endif

// ==== core/cpc_sync.v ====
`timescale 1ns/100ps
`default_nettype none

// three-stage pin synchroniser; level moves once stages two and three agree
module cpc_sync #(
	parameter W = 1
) (
	input  wire         clk,    // clock
	input  wire         reset,  // sync reset
	input  wire [W-1:0] d,      // async pins
	output reg  [W-1:0] q       // filtered level
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;
	integer i;

	always @(posedge clk) begin
		if (reset) begin
			s1_reg <= {W{1'b0}};
			s2_reg <= {W{1'b0}};
			s3_reg <= {W{1'b0}};
			q      <= {W{1'b0}};
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_reg[i] == s3_reg[i])
					q[i] <= s3_reg[i];
			end
		end
	end
endmodule

`default_nettype wire

// ==== verif/cpc_analog.sv ====
`timescale 1ns/100ps
`default_nettype none
// analog front end: turns node voltages, currents and temperature into comparator levels
module cpc_analog (
	input  var int adp_mv,   // adapter node, mV
	input  var int sys_mv,   // system rail, mV
	input  var int ceil_mv,  // programmed system ceiling, mV
	input  var int cmp_mv,   // comparator node, mV
	input  var int temp_c,   // junction, deg C
	input  var int adp_ma,   // adapter current, mA
	input  var int bat_ma,   // discharge current, mA
	output logic   adp_over, // adapter over limit
	output logic   adp_rel,  // adapter below release
	output logic   sys_over, // system over ceiling plus margin
	output logic   sys_rel,  // system back under hysteresis
	output logic   cur_a,    // adapter current trip
	output logic   cur_b,    // discharge current trip
	output logic   t_over,   // too hot
	output logic   t_rel,    // cooled down
	output logic   cmp_lo,   // node above low reference
	output logic   cmp_hi    // node above high reference
);
	assign adp_over = adp_mv > 23400;
	assign adp_rel  = adp_mv < 23040;
	assign sys_over = sys_mv > ceil_mv + 600;
	assign sys_rel  = sys_mv < ceil_mv + 300;
	assign cur_a    = adp_ma > 12000;
	assign cur_b    = bat_ma > 16000;
	assign t_over   = temp_c > 140;
	assign t_rel    = temp_c < 120;
	assign cmp_lo   = cmp_mv > 1200;
	assign cmp_hi   = cmp_mv > 2000;
endmodule
`default_nettype wire

// ==== verif/cpc_ctl_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module cpc_ctl_checker (
	input wire logic clk,                  // clock
	input wire logic reset,                // sync reset
	input wire logic battery_above_limit,  // battery above limit
	input wire logic adapter_sense_over,   // adapter over limit
	input wire logic system_rail_over,     // system over
	input wire logic system_rail_release,  // system released
	input wire logic temp_over,            // too hot
	input wire logic adapter_switch_gate,  // adapter switch
	input wire logic adapter_present_flag, // adapter ok
	input wire logic battery_gate,         // battery gate
	input wire logic switching_enable,     // switching
	input wire logic output_function_on,   // output running
	input wire logic regulator_enable,     // regulator on
	input wire logic system_ov_flag        // system overvoltage
);
	localparam int QUAL = 2500;
	localparam int REL = 25000;
	logic [15:0] aov_run;
	logic [15:0] aov_age;
	logic [15:0] ot_age;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// saturating, so a long quiet spell never wraps back into range
	always @(posedge clk) begin
		if (reset) begin
			aov_run <= 16'h0;
			aov_age <= 16'hffff;
			ot_age  <= 16'hffff;
		end else begin
			aov_run <= adapter_sense_over ? aov_run + {15'h0, aov_run != 16'hffff} : 16'h0;
			aov_age <= adapter_sense_over ? 16'h0 : aov_age + {15'h0, aov_age != 16'hffff};
			ot_age  <= temp_over ? 16'h0 : ot_age + {15'h0, ot_age != 16'hffff};
		end
	end
	property p_aov_trip;
		aov_run > QUAL + 20 |-> !adapter_switch_gate && !adapter_present_flag && battery_gate && !switching_enable;
	endproperty
	a_aov_trip: assert property (p_aov_trip) else $error("adapter overvoltage not acted on");
	property p_aov_early;
		$fell(adapter_switch_gate) && adapter_sense_over |-> aov_run > QUAL;
	endproperty
	a_aov_early: assert property (p_aov_early) else $error("adapter switch opened too early");
	property p_aov_rel;
		$rose(adapter_switch_gate) |-> aov_age > REL;
	endproperty
	a_aov_rel: assert property (p_aov_rel) else $error("adapter switch closed too early");
	property p_sov_trip;
		system_rail_over [*8] |-> system_ov_flag && !switching_enable;
	endproperty
	a_sov_trip: assert property (p_sov_trip) else $error("system overvoltage missed");
	property p_sov_rel;
		system_rail_release [*8] |-> !system_ov_flag;
	endproperty
	a_sov_rel: assert property (p_sov_rel) else $error("system overvoltage not released");
	property p_ot_trip;
		temp_over [*8] |-> !regulator_enable && !switching_enable;
	endproperty
	a_ot_trip: assert property (p_ot_trip) else $error("over-temperature missed");
	property p_ot_rel;
		$rose(regulator_enable) |-> ot_age > REL;
	endproperty
	a_ot_rel: assert property (p_ot_rel) else $error("regulator back too early");
	property p_out_batt;
		$rose(output_function_on) |-> battery_above_limit;
	endproperty
	a_out_batt: assert property (p_out_batt) else $error("output started on low battery");
endmodule
bind cpc_ctl cpc_ctl_checker cpc_ctl_checker_i (.clk, .reset, .battery_above_limit, .adapter_sense_over,
	.system_rail_over, .system_rail_release, .temp_over, .adapter_switch_gate, .adapter_present_flag,
	.battery_gate, .switching_enable, .output_function_on, .regulator_enable, .system_ov_flag);
`default_nettype wire

// ==== verif/tb_charger_protection_comparator_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_charger_protection_comparator_ctl;
	logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, pin_in = 0, batt_only = 0, batt_hi = 1, rail_good = 1;
	logic [7:0] reg_addr = 8'h0;
	logic [15:0] reg_wdata = 16'h0;
	logic [15:0] d;
	wire [15:0] reg_rdata;
	wire cmp_out, adp_over, adp_rel, sys_over, sys_rel, cur_a, cur_b, t_over, t_rel, cmp_lo, cmp_hi;
	wire sw_gate, bat_gate, ac_flag, sw_en, out_on, reg_en, sov_flag, cmp_en;
	int adp_mv = 20000, sys_mv = 8000, ceil_mv = 8400, cmp_mv = 0, temp_c = 50, adp_ma = 0, bat_ma = 0;
	int num_errors = 0, num_checks = 0, n;
	always #2 clk = ~clk;
	cpc_analog cpc_analog_i (.adp_mv(adp_mv), .sys_mv(sys_mv), .ceil_mv(ceil_mv), .cmp_mv(cmp_mv),
		.temp_c(temp_c), .adp_ma(adp_ma), .bat_ma(bat_ma), .adp_over(adp_over), .adp_rel(adp_rel),
		.sys_over(sys_over), .sys_rel(sys_rel), .cur_a(cur_a), .cur_b(cur_b), .t_over(t_over),
		.t_rel(t_rel), .cmp_lo(cmp_lo), .cmp_hi(cmp_hi));
	// window shortened from the default but still past the run so the trip count never restarts mid-test
	cpc_ctl #(.OC_WIN_CYC(200000), .LONG_CYC(400), .SHORT_CYC(100)) cpc_ctl_i (.clk(clk), .reset(reset),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.shared_enable_or_cmp_in_pin(pin_in), .shared_pgood_or_cmp_out_pin(cmp_out),
		.cmp_above_ref_low(cmp_lo), .cmp_above_ref_high(cmp_hi), .battery_only(batt_only),
		.battery_above_limit(batt_hi), .output_rail_good(rail_good), .adapter_sense_over(adp_over),
		.adapter_sense_release(adp_rel), .system_rail_over(sys_over), .system_rail_release(sys_rel),
		.adapter_current_trip(cur_a), .battery_current_trip(cur_b), .temp_over(t_over),
		.temp_release(t_rel), .adapter_switch_gate(sw_gate), .battery_gate(bat_gate),
		.adapter_present_flag(ac_flag), .switching_enable(sw_en), .output_function_on(out_on),
		.regulator_enable(reg_en), .system_ov_flag(sov_flag), .comparator_enable(cmp_en));
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1;
		tick(1);
		reg_wr = 0;
		tick(1);
	endtask
	task rd(input logic [7:0] a);
		reg_addr = a;
		reg_rd = 1;
		tick(1);
		reg_rd = 0;
		d = reg_rdata;
		tick(1);
	endtask
	task wait_gate(input logic lv, input int mx);
		n = 0;
		while (sw_gate !== lv && n < mx) begin
			tick(1);
			n++;
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		tick(100000);
		num_errors++;
		$display("watchdog expired");
		test_done;
	end
	initial begin
		tick(4);
		reset = 0;
		tick(10);
		rd(8'h3c);
		`CHK("cfg_a", 16'h0000, d)
		wr(8'h3d, 16'h2814);
		wr(8'h3a, 16'hffff);
		rd(8'h3d);
		`CHK("cfg_b", 16'h2814, d)
		rd(8'h3a);
		`CHK("info", 16'h8000, d)
		rd(8'h3b);
		`CHK("unmapped", 16'h0000, d)
		`CHK("gate", 1'b1, sw_gate & ac_flag & reg_en)
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(8'h3d, {11'h0, i[1], 1'b0, i[0], 2'h0});
			for (int j = 0; j < 3; j++) begin
				cmp_mv = 500 + 1000 * j;
				pin_in = cmp_mv > 1200;
				tick(8);
				`CHK("cmp_out", (cmp_mv > (i[1] ? 2000 : 1200)) ^ i[0], cmp_out)
				`CHK("cmp_en", 1'b1, cmp_en & ~out_on)
			end
		end
		$display("test comparator done");
		batt_only = 1;
		wr(8'h3d, 16'h0000);
		tick(8);
		rd(8'h3a);
		`CHK("ref_off", 2'b00, {cmp_en, d[15]})
		wr(8'h3c, 16'h0008);
		tick(8);
		rd(8'h3a);
		`CHK("ref_on", 2'b11, {cmp_en, d[15]})
		batt_only = 0;
		wr(8'h3c, 16'h0000);
		wr(8'h3d, 16'h0008);
		tick(8);
		`CHK("both_off", 3'b000, {cmp_en, cmp_out, out_on})
		$display("test modes done");
		wr(8'h3d, 16'h2000);
		wr(8'h3c, 16'h0800);
		tick(50);
		`CHK("out_early", 1'b0, out_on)
		tick(100);
		rd(8'h3a);
		`CHK("out_run", 4'hf, {out_on, cmp_en, d[6:5]})
		batt_hi = 0;
		tick(10);
		`CHK("out_lowbat", 1'b0, out_on)
		batt_hi = 1;
		wr(8'h3d, 16'h2008);
		pin_in = 0;
		tick(200);
		`CHK("pin_low", 1'b0, out_on)
		pin_in = 1;
		tick(150);
		`CHK("pin_high", 2'b11, {out_on, cmp_out})
		rail_good = 0;
		tick(8);
		`CHK("pgood", 1'b0, cmp_out)
		rail_good = 1;
		wr(8'h3c, 16'h0000);
		wr(8'h3d, 16'h0000);
		tick(10);
		$display("test output done");
		sys_mv = 9100;
		tick(10);
		`CHK("sov", 2'b10, {sov_flag, sw_en})
		sys_mv = 8800;
		tick(10);
		`CHK("sov_hyst", 1'b1, sov_flag)
		sys_mv = 8600;
		tick(8);
		`CHK("sov_rel", 2'b01, {sov_flag, sw_en})
		$display("test system done");
		adp_mv = 24000;
		tick(2400);
		`CHK("aov_early", 1'b1, sw_gate)
		tick(200);
		`CHK("aov", 4'b0010, {sw_gate, ac_flag, bat_gate, sw_en})
		adp_mv = 20000;
		temp_c = 150;
		tick(10);
		`CHK("ot", 2'b00, {reg_en, sw_en})
		temp_c = 100;
		tick(24900);
		`CHK("rel_early", 2'b00, {sw_gate, reg_en})
		tick(200);
		`CHK("rel", 4'hf, {sw_gate, ac_flag, reg_en, sw_en})
		$display("test adapter and thermal done");
		wr(8'h3d, 16'h0800);
		adp_ma = 13000;
		wait_gate(0, 12000);
		`CHK("oc_hold", 1'b1, sw_gate)
		adp_ma = 0;
		bat_ma = 17000;
		wait_gate(0, 24000);
		bat_ma = 0;
		`CHK("oc_time", 1'b1, n > 12990 && n < 23020)
		`CHK("oc_off", 2'b00, {ac_flag, sw_en})
		wait_gate(1, 1000);
		`CHK("oc_retry", 1'b1, n > 90 && n < 130)
		wr(8'h3d, 16'h0802);
		adp_ma = 13000;
		tick(30100);
		`CHK("ocp_off", 3'b111, {sw_gate, ac_flag, sw_en})
		adp_ma = 0;
		$display("test overcurrent done");
		test_done;
	end
endmodule
`default_nettype wire
